// file: src/tmra_consts.svh
// Constants of the general timer channel: register offsets, field positions,
// reset values and prescaler ratios. Included by the design files.
`ifndef TMRA_CONSTS_SVH
`define TMRA_CONSTS_SVH

// Register byte offsets
`define TMRA_OFF_START   8'h00
`define TMRA_OFF_MODE    8'h04
`define TMRA_OFF_COUNT   8'h08
`define TMRA_OFF_EVSEL   8'h0c
`define TMRA_OFF_STATUS  8'h10

// Mode register fields
`define TMRA_MODE_OP_LSB     0
`define TMRA_MODE_PULSE_BIT  2
`define TMRA_MODE_CLK_LSB    3
`define TMRA_MODE_DIRSRC_BIT 5
`define TMRA_MODE_FREE_BIT   6
`define TMRA_MODE_UP_BIT     7
`define TMRA_MODE_PDIR_BIT   8
`define TMRA_MODE_PDAT_BIT   9
`define TMRA_MODE_WIDTH      10

// Reset values
`define TMRA_RST_MODE    10'h000
`define TMRA_RST_COUNT   16'h0000
`define TMRA_RST_EVSEL   2'h0

// Prescaler ratios and terminal count
`define TMRA_DIV8        8
`define TMRA_DIV32       32
`define TMRA_MAX_COUNT   16'hffff

// Bus responses
`define TMRA_RESP_OKAY   2'h0
`define TMRA_RESP_SLVERR 2'h2

`endif

// file: src/tmra_pkg.sv
// Types of the general timer channel.
// Assumes nothing of its surroundings.
package tmra_pkg;

	typedef enum logic [1:0] {
		TMRA_OP_TIMER,
		TMRA_OP_EVENT,
		TMRA_OP_ONESHOT,
		TMRA_OP_PWM
	} tmra_op_t;

	typedef enum logic [1:0] {
		TMRA_CLK_UNDIV,
		TMRA_CLK_DIV8,
		TMRA_CLK_DIV32,
		TMRA_CLK_SPARE
	} tmra_clk_t;

	typedef enum logic [1:0] {
		TMRA_EV_NONE,
		TMRA_EV_B_THIRD,
		TMRA_EV_FIFTH_A,
		TMRA_EV_SECOND_A
	} tmra_ev_t;

endpackage

// file: src/tmra_prescaler.sv
// Prescaler: one-cycle ticks of the undivided, divide-by-8 and divide-by-32 clocks.
// Assumes one system clock with synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
`include "tmra_consts.svh"

module tmra_prescaler #(
	parameter int DIV8  = `TMRA_DIV8,
	parameter int DIV32 = `TMRA_DIV32
) (
	// Clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// Ticks
	output logic      undivided_clock,
	output logic      div8_clock,
	output logic      div32_clock
);

	logic [$clog2(DIV32)-1:0] div_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_reg <= '0;
		end else begin
			div_reg <= div_reg + 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			undivided_clock <= 1'b0;
			div8_clock      <= 1'b0;
			div32_clock     <= 1'b0;
		end else begin
			undivided_clock <= 1'b1;
			div8_clock      <= (div_reg % DIV8) == (DIV8 - 1);
			div32_clock     <= div_reg == $bits(div_reg)'(DIV32 - 1);
		end
	end

endmodule
`default_nettype wire

// file: src/tmra_timer.sv
// General 16-bit timer channel, timer and event counter modes, AXI4-Lite registers.
// Assumes neighbouring overflow events are one-cycle pulses on aclk.
// Notes on behaviour
// - Timer mode counts undivided, div8 or div32
// - Timer mode decrements, reloads on underflow
// - Down underflow rate is source over n+1
// - Count only while start flag is 1
// - Timer mode requests interrupt on underflow
// - Count register read returns live counter
// - Write while stopped loads reload and counter
// - Write while running loads reload only
// - Timer mode pulse output toggles on underflow
// - Event mode counts selected timer overflow
// - Direction chosen by pin or software
// - Event mode reloads on wrap unless free-run
// - Up overflow rate is events over FFFF-n+1
// - Event mode interrupts on overflow or underflow
// - Free-run wraps without reloading
// - Event mode pulse output toggles on wrap
// - Pin is port, pulse output or direction
// - Event select 01 B, 10 fifth, 11 second
// - Mode field 01 selects event counter
// - Pulse enable 1 drives pin, 0 port
//
// Chosen here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "tmra_consts.svh"

module tmra_timer #(
	parameter int WIDTH = 16
) (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write address
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic [2:0]  s_axi_awprot,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic [2:0]  s_axi_arprot,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Overflow events of other timers
	input  wire logic        b_group_third_timer,
	input  wire logic        neighbour_timer_low,
	input  wire logic        neighbour_timer_high,
	// Timer pin
	input  wire logic        timer_toggle_pin_in,
	output logic             timer_toggle_pin_out,
	output logic             timer_toggle_pin_oe_n,
	// Interrupt request
	output logic             irq_request
);

	// Register state
	logic                            start_reg;
	logic [`TMRA_MODE_WIDTH-1:0]     mode_reg;
	logic [WIDTH-1:0]                reload_reg;
	logic [WIDTH-1:0]                count_reg;
	logic [1:0]                      evsel_reg;
	logic                            toggle_reg;
	logic                            pin_sync1_reg;
	logic                            pin_sync2_reg;

	// Bus state
	logic                            aw_have_reg;
	logic [7:0]                      aw_addr_reg;
	logic                            w_have_reg;
	logic [31:0]                     w_data_reg;
	logic [3:0]                      w_strb_reg;
	logic                            wr_fire;

	// Decoded fields
	tmra_pkg::tmra_op_t              op_mode;
	tmra_pkg::tmra_clk_t             clk_sel;
	tmra_pkg::tmra_ev_t              ev_sel;
	logic                            pulse_en;
	logic                            dir_from_pin;
	logic                            free_run;
	logic                            count_up;

	// Count source
	logic                            undivided_clock;
	logic                            div8_clock;
	logic                            div32_clock;
	logic                            src_tick;
	logic                            step;
	logic                            at_terminal;
	logic                            wrap;
	logic [WIDTH-1:0]                count_next;

	// Register index for a byte address; 3'h7 means unmapped
	function automatic logic [2:0] reg_index(input logic [7:0] addr);
		case (addr)
			`TMRA_OFF_START:  reg_index = 3'h0;
			`TMRA_OFF_MODE:   reg_index = 3'h1;
			`TMRA_OFF_COUNT:  reg_index = 3'h2;
			`TMRA_OFF_EVSEL:  reg_index = 3'h3;
			`TMRA_OFF_STATUS: reg_index = 3'h4;
			default:          reg_index = 3'h7;
		endcase
	endfunction

	// Byte-lane merge of a write into an old value
	function automatic logic [31:0] merge(input logic [31:0] old_val,
		input logic [31:0] new_val, input logic [3:0] strb);
		for (int i = 0; i < 4; i++) begin
			merge[i*8 +: 8] = strb[i] ? new_val[i*8 +: 8] : old_val[i*8 +: 8];
		end
	endfunction

	tmra_prescaler u_prescaler (
		.aclk            (aclk),
		.aresetn         (aresetn),
		.undivided_clock (undivided_clock),
		.div8_clock      (div8_clock),
		.div32_clock     (div32_clock)
	);

	// Field decode
	assign op_mode      = tmra_pkg::tmra_op_t'(mode_reg[`TMRA_MODE_OP_LSB +: 2]);
	assign clk_sel      = tmra_pkg::tmra_clk_t'(mode_reg[`TMRA_MODE_CLK_LSB +: 2]);
	assign ev_sel       = tmra_pkg::tmra_ev_t'(evsel_reg);
	assign pulse_en     = mode_reg[`TMRA_MODE_PULSE_BIT];
	assign dir_from_pin = mode_reg[`TMRA_MODE_DIRSRC_BIT];
	assign free_run     = mode_reg[`TMRA_MODE_FREE_BIT];

	// Direction: timer mode always down, event mode from pin or software
	always_comb begin
		if (op_mode != tmra_pkg::TMRA_OP_EVENT) begin
			count_up = 1'b0;
		end else if (dir_from_pin && !pulse_en) begin
			count_up = pin_sync2_reg;
		end else begin
			count_up = mode_reg[`TMRA_MODE_UP_BIT];
		end
	end

	// Count source selection
	always_comb begin
		src_tick = 1'b0;
		case (op_mode)
			tmra_pkg::TMRA_OP_TIMER: begin
				case (clk_sel)
					tmra_pkg::TMRA_CLK_UNDIV: src_tick = undivided_clock;
					tmra_pkg::TMRA_CLK_DIV8:  src_tick = div8_clock;
					default:                  src_tick = div32_clock;
				endcase
			end
			tmra_pkg::TMRA_OP_EVENT: begin
				case (ev_sel)
					tmra_pkg::TMRA_EV_B_THIRD:  src_tick = b_group_third_timer;
					tmra_pkg::TMRA_EV_FIFTH_A:  src_tick = neighbour_timer_low;
					tmra_pkg::TMRA_EV_SECOND_A: src_tick = neighbour_timer_high;
					default:                    src_tick = 1'b0;
				endcase
			end
			default: src_tick = 1'b0;
		endcase
	end

	assign step        = start_reg && src_tick;
	assign at_terminal = count_up ? (count_reg == `TMRA_MAX_COUNT) : (count_reg == '0);
	assign wrap        = step && at_terminal;

	// Next counter value on a source tick
	always_comb begin
		if (!at_terminal) begin
			count_next = count_up ? count_reg + 1'b1 : count_reg - 1'b1;
		end else if (op_mode == tmra_pkg::TMRA_OP_EVENT && free_run) begin
			count_next = count_up ? '0 : `TMRA_MAX_COUNT;
		end else begin
			count_next = reload_reg;
		end
	end

	// Counter
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count_reg <= `TMRA_RST_COUNT;
		end else if (wr_fire && reg_index(aw_addr_reg) == 3'h2 && !start_reg) begin
			count_reg <= WIDTH'(merge({16'h0000, count_reg}, w_data_reg, w_strb_reg));
		end else if (step) begin
			count_reg <= count_next;
		end
	end

	// Reload register takes every count write
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			reload_reg <= `TMRA_RST_COUNT;
		end else if (wr_fire && reg_index(aw_addr_reg) == 3'h2) begin
			reload_reg <= WIDTH'(merge({16'h0000, reload_reg}, w_data_reg, w_strb_reg));
		end
	end

	// Interrupt request pulse
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_request <= 1'b0;
		end else begin
			irq_request <= wrap;
		end
	end

	// Pulse output level
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			toggle_reg <= 1'b0;
		end else if (wrap && pulse_en) begin
			toggle_reg <= ~toggle_reg;
		end
	end

	// Pin input synchroniser
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_sync1_reg <= 1'b0;
			pin_sync2_reg <= 1'b0;
		end else begin
			pin_sync1_reg <= timer_toggle_pin_in;
			pin_sync2_reg <= pin_sync1_reg;
		end
	end

	// Pin function: pulse output, direction input or general port
	always_comb begin
		if (pulse_en) begin
			timer_toggle_pin_oe_n = 1'b0;
			timer_toggle_pin_out  = toggle_reg;
		end else if (op_mode == tmra_pkg::TMRA_OP_EVENT && dir_from_pin) begin
			timer_toggle_pin_oe_n = 1'b1;
			timer_toggle_pin_out  = 1'b0;
		end else begin
			timer_toggle_pin_oe_n = ~mode_reg[`TMRA_MODE_PDIR_BIT];
			timer_toggle_pin_out  = mode_reg[`TMRA_MODE_PDAT_BIT];
		end
	end

	// Control registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			start_reg <= 1'b0;
			mode_reg  <= `TMRA_RST_MODE;
			evsel_reg <= `TMRA_RST_EVSEL;
		end else if (wr_fire) begin
			case (reg_index(aw_addr_reg))
				3'h0: start_reg <= w_strb_reg[0] ? w_data_reg[0] : start_reg;
				3'h1: mode_reg  <= `TMRA_MODE_WIDTH'(merge({22'h000000, mode_reg},
					w_data_reg, w_strb_reg));
				3'h3: evsel_reg <= w_strb_reg[0] ? w_data_reg[1:0] : evsel_reg;
				default: start_reg <= start_reg;
			endcase
		end
	end

	// Write address and data capture, either order
	assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
	assign s_axi_wready  = !w_have_reg && !s_axi_bvalid;
	assign wr_fire       = aw_have_reg && w_have_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_have_reg <= 1'b1;
			aw_addr_reg <= s_axi_awaddr;
		end else if (wr_fire) begin
			aw_have_reg <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_have_reg <= 1'b0;
			w_data_reg <= 32'h00000000;
			w_strb_reg <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_have_reg <= 1'b1;
			w_data_reg <= s_axi_wdata;
			w_strb_reg <= s_axi_wstrb;
		end else if (wr_fire) begin
			w_have_reg <= 1'b0;
		end
	end

	// Write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `TMRA_RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (reg_index(aw_addr_reg) == 3'h7) ? `TMRA_RESP_SLVERR
				: `TMRA_RESP_OKAY;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Read channel
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= `TMRA_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= `TMRA_RESP_OKAY;
			case (reg_index(s_axi_araddr))
				3'h0: s_axi_rdata <= {31'h00000000, start_reg};
				3'h1: s_axi_rdata <= {22'h000000, mode_reg};
				3'h2: s_axi_rdata <= {16'h0000, count_reg};
				3'h3: s_axi_rdata <= {30'h00000000, evsel_reg};
				3'h4: s_axi_rdata <= {29'h00000000, count_up, toggle_reg, pin_sync2_reg};
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `TMRA_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// file: verification/tmra_timer_chk.sv
// Checker of the timer channel's bus handshakes, interrupt pulse and toggle pin.
// Assumes it is bound to tmra_timer and sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module tmra_timer_chk (
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// Register bus
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// Pin and interrupt
	input wire logic        timer_toggle_pin_out,
	input wire logic        timer_toggle_pin_oe_n,
	input wire logic        irq_request
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence pin_driven;
		!timer_toggle_pin_oe_n && $past(!timer_toggle_pin_oe_n);
	endsequence

	irq_one_cycle_a: assert property (irq_request |=> !irq_request)
		else $error("interrupt request longer than one cycle");
	pin_toggle_a: assert property (pin_driven and irq_request |->
		timer_toggle_pin_out != $past(timer_toggle_pin_out))
		else $error("pulse pin did not toggle on wrap");
	write_answer_a: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
		else $error("write response late");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while data pending");
endmodule

bind tmra_timer tmra_timer_chk u_tmra_timer_chk (.*);

`default_nettype wire

// file: verification/tmra_partner.sv
// Neighbouring timers that send overflow pulses, and the pin's outside world.
// Assumes one clock shared with the timer channel.
`timescale 1ns/1ps
`default_nettype none

module tmra_partner (
	// Clock
	input  wire logic aclk,
	// Overflow events
	output wire logic b_group_third_timer,
	output wire logic neighbour_timer_low,
	output wire logic neighbour_timer_high,
	// Pin
	input  wire logic timer_toggle_pin_out,
	input  wire logic timer_toggle_pin_oe_n,
	output wire logic timer_toggle_pin_in
);
	logic [2:0] ev = 3'h0;
	logic       up = 1'b0;

	// One-cycle overflow pulses, spaced apart
	assign {neighbour_timer_high, neighbour_timer_low, b_group_third_timer} = ev;
	// Pin level: timer drive when enabled, else the outside direction level
	assign timer_toggle_pin_in = timer_toggle_pin_oe_n ? up : timer_toggle_pin_out;

	task pulse(input int k);
		ev <= 3'h1 << k;
		@(posedge aclk);
		ev <= 3'h0;
		@(posedge aclk);
	endtask

	task set_up(input logic v);
		up <= v;
	endtask
endmodule

`default_nettype wire

// file: verification/tb_tmra_timer.sv
// Testbench of the timer channel: register bus tasks, timer and event mode runs.
// Assumes the design's register map and a partner model for events and pin.
`timescale 1ns/1ps
`default_nettype none

module tb_tmra_timer;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00;
	logic [7:0]  s_axi_araddr = 8'h00;
	logic [2:0]  s_axi_awprot = 3'h0;
	logic [2:0]  s_axi_arprot = 3'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_awvalid = 1'b0;
	logic        s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire  [1:0]  s_axi_bresp, s_axi_rresp;
	wire  [31:0] s_axi_rdata;
	wire         b_group_third_timer, neighbour_timer_low, neighbour_timer_high;
	wire         timer_toggle_pin_in, timer_toggle_pin_out, timer_toggle_pin_oe_n;
	wire         irq_request;
	int          mismatches = 0;
	int          cmp_count = 0;
	int          irq_cnt = 0;
	int          c;
	logic        p;

	tmra_timer u_tmra_timer (.*);
	tmra_partner u_tmra_partner (.*);

	always #50 aclk = ~aclk;
	always @(posedge aclk) if (irq_request === 1'b1) irq_cnt <= irq_cnt + 1;

	task end_sim;
		$display("checks %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 60; n++) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1) break;
		end
		if (n == 60) begin
			mismatches++;
			end_sim;
		end
		s_axi_bready <= 1'b0;
		chk("bresp", er, s_axi_bresp);
		@(posedge aclk);
	endtask

	task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		int n;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 60; n++) begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1) break;
		end
		if (n == 60) begin
			mismatches++;
			end_sim;
		end
		s_axi_rready <= 1'b0;
		chk("rdata", e, s_axi_rdata);
		chk("rresp", er, s_axi_rresp);
		@(posedge aclk);
	endtask

	// Cycles up to the next interrupt pulse
	task per(output int n);
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (irq_request !== 1'b1 && n < 400);
		if (irq_request !== 1'b1) begin
			mismatches++;
			end_sim;
		end
	endtask

	task ev_case(input logic [1:0] sel, input int ln, input logic [31:0] md,
		input logic up, input logic [15:0] n, input int nev, input int ei,
		input logic [15:0] ec);
		int i0;
		u_tmra_partner.set_up(up);
		wr(8'h0c, {30'h0, sel}, 2'h0);
		wr(8'h04, md, 2'h0);
		wr(8'h08, {16'h0, n}, 2'h0);
		wr(8'h00, 32'h1, 2'h0);
		i0 = irq_cnt;
		p = timer_toggle_pin_out;
		repeat (nev) u_tmra_partner.pulse(ln);
		repeat (4) @(posedge aclk);
		chk("irq count", ei, irq_cnt - i0);
		if (md[2]) chk("pulse pin", p ^ ei[0], timer_toggle_pin_out);
		if (md[5] && !md[2]) chk("pin oe_n", 1'b1, timer_toggle_pin_oe_n);
		rd(8'h08, {16'h0, ec}, 2'h0);
		wr(8'h00, 32'h0, 2'h0);
	endtask

	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(8'h04, 32'h0, 2'h0);
		rd(8'h08, 32'h0, 2'h0);
		rd(8'h20, 32'h0, 2'h2);
		wr(8'h20, 32'h5, 2'h2);
		for (int k = 0; k < 3; k++) begin
			wr(8'h04, 32'h4 | (k << 3), 2'h0);
			wr(8'h08, 32'h4, 2'h0);
			rd(8'h08, 32'h4, 2'h0);
			wr(8'h00, 32'h1, 2'h0);
			per(c);
			p = timer_toggle_pin_out;
			per(c);
			chk("timer period", (k == 0 ? 1 : k == 1 ? 8 : 32) * 5, c);
			chk("pin toggle", !p, timer_toggle_pin_out);
			chk("pin oe_n", 1'b0, timer_toggle_pin_oe_n);
			wr(8'h00, 32'h0, 2'h0);
		end
		wr(8'h04, 32'h4, 2'h0);
		wr(8'h00, 32'h1, 2'h0);
		wr(8'h08, 32'h9, 2'h0);
		per(c);
		per(c);
		chk("reload period", 10, c);
		wr(8'h00, 32'h0, 2'h0);
		c = irq_cnt;
		wr(8'h08, 32'h7, 2'h0);
		repeat (20) @(posedge aclk);
		rd(8'h08, 32'h7, 2'h0);
		chk("stopped irq", c, irq_cnt);
		ev_case(2'h1, 0, 32'h001, 1'b0, 16'h0003, 4, 1, 16'h0003);
		ev_case(2'h2, 1, 32'h001, 1'b0, 16'h0003, 3, 0, 16'h0000);
		ev_case(2'h3, 2, 32'h081, 1'b0, 16'hfffd, 3, 1, 16'hfffd);
		ev_case(2'h2, 0, 32'h001, 1'b0, 16'h0003, 4, 0, 16'h0003);
		ev_case(2'h0, 0, 32'h001, 1'b0, 16'h0003, 4, 0, 16'h0003);
		ev_case(2'h1, 0, 32'h0c1, 1'b0, 16'hfffe, 2, 1, 16'h0000);
		ev_case(2'h1, 0, 32'h041, 1'b0, 16'h0000, 1, 1, 16'hffff);
		ev_case(2'h1, 0, 32'h021, 1'b1, 16'hfffd, 3, 1, 16'hfffd);
		ev_case(2'h1, 0, 32'h021, 1'b0, 16'h0003, 4, 1, 16'h0003);
		ev_case(2'h1, 0, 32'h005, 1'b0, 16'h0001, 2, 1, 16'h0001);
		ev_case(2'h1, 0, 32'h002, 1'b0, 16'h0003, 4, 0, 16'h0003);
		end_sim;
	end

	initial begin
		#9000000;
		mismatches++;
		end_sim;
	end
endmodule

`default_nettype wire
